/* File: core/tmc_regs.vh */
`ifndef TMC_REGS_VH
`define TMC_REGS_VH
// register word offsets (byte address = 4 * index)
`define TMC_IDX_COUNT     3'h0
`define TMC_IDX_CCF       3'h1
`define TMC_IDX_CCS       3'h2
`define TMC_IDX_MODE      3'h3
`define TMC_IDX_CAPCTL    3'h4
`define TMC_IDX_OUTCTL    3'h5
`define TMC_IDX_EDGESEL   3'h6
// mode control fields
`define TMC_MODE_OVF_BIT  0
`define TMC_MODE_RUN_LO   2
`define TMC_MODE_RUN_HI   3
// capture control fields
`define TMC_CAP_CCF_BIT   0
`define TMC_CAP_SRC_BIT   1
`define TMC_CAP_CCS_BIT   2
// output control fields
`define TMC_OUT_OSPE_BIT  5
`define TMC_OUT_OSPT_BIT  6
// edge select fields (2 bits each: 00 fall,01 rise,10 none,11 both)
`define TMC_EDGE_IN1_LO   0
`define TMC_EDGE_IN2_LO   2
// run modes
`define TMC_RUN_STOP      2'h0
`define TMC_RUN_FREE      2'h1
`define TMC_RUN_CLR_EDGE  2'h2
`define TMC_RUN_CLR_MATCH 2'h3
// reset values
`define TMC_RST_COUNT     16'h0000
`define TMC_RST_CC        16'h0000
`define TMC_RST_CTL       8'h00
`endif

/* File: core/tmc_edge_detect.v */
`include "tmc_regs.vh"
module tmc_edge_detect (
  input  wire       mclk,
  input  wire       srst,
  input  wire       pin,
  input  wire [1:0] edge_sel,
  output reg        valid_edge,
  output reg        reverse_edge
);
  reg sync1;
  reg sync2;
  reg prev;
  wire rise;
  wire fall;
  assign rise = sync2 & ~prev;
  assign fall = ~sync2 & prev;
  always @(posedge mclk) begin
    if (srst) begin
      sync1        <= 1'b0;
      sync2        <= 1'b0;
      prev         <= 1'b0;
      valid_edge   <= 1'b0;
      reverse_edge <= 1'b0;
    end else begin
      sync1 <= pin;
      sync2 <= sync1;
      prev  <= sync2;
      case (edge_sel)
        2'h0: begin
          valid_edge   <= fall;
          reverse_edge <= rise;
        end
        2'h1: begin
          valid_edge   <= rise;
          reverse_edge <= fall;
        end
        2'h3: begin
          valid_edge   <= rise | fall;
          reverse_edge <= 1'b0;
        end
        default: begin
          valid_edge   <= 1'b0;
          reverse_edge <= 1'b0;
        end
      endcase
    end
  end
endmodule

/* File: core/tmc_avalon_slave.v */
`include "tmc_regs.vh"
module tmc_avalon_slave (
  input  wire        mclk,
  input  wire        srst,
  input  wire [4:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  input  wire [3:0]  avs_byteenable,
  output wire        avs_waitrequest,
  output reg  [31:0] avs_readdata,
  input  wire [31:0] rd_word,
  output wire [2:0]  reg_index,
  output wire        wr_stb,
  output wire        rd_stb
);
  // one wait cycle per access, then the ack cycle
  reg ack;
  always @(posedge mclk) begin
    if (srst) begin
      ack          <= 1'b0;
      avs_readdata <= 32'h00000000;
    end else begin
      ack <= (avs_read | avs_write) & ~ack;
      if (avs_read & ~ack)
        avs_readdata <= rd_word;
    end
  end
  assign avs_waitrequest = (avs_read | avs_write) & ~ack;
  assign reg_index = avs_address[4:2];
  assign wr_stb = avs_write & ack & (avs_byteenable[1:0] == 2'h3);
  assign rd_stb = avs_read & ack;
endmodule

/* File: core/tmc_timer.v */
// Functional notes
// R1 - 16-bit read-only up-counter, increments each clock when running.
// R2 - count reads live when running, 0000H when stopped.
// R3 - count clears on reset and when run mode cleared to 00.
// R4 - edge-clear mode: valid first-input edge clears count.
// R5 - match-clear mode: count equal to first register clears count.
// R6 - one-shot: soft trigger or first-input edge clears count.
// R7 - both capture/compare registers 16 bits, whole access, reset 0000H.
// R8 - software leaves first register alone while running.
// R9 - first compare: continuous compare, match interrupt, value held.
// R10 - first capture: reverse first-input edge or second-input edge.
// R11 - second compare: continuous compare, second match interrupt.
// R12 - second capture: loads count on valid first-input edge.
// R13 - stop colliding with capture gives undefined capture value.
// R14 - software stops timer before switching capture to compare.
// R15 - captured value kept until reset; rewrite before compare use.
// R16 - interval modes: first compare nonzero, mask second interrupt.
// R17 - PPG: second compare no greater than first.
// R18 - one-shot: the two compare values never equal.
// R19 - zero compare matches only on step 0000H to 0001H.
// R20 - reverse-phase capture gives no interrupt; second input interrupts. Code: only with source select 1, none when second input is capture source.
// R21 - second register capture ignores capture source select.
// R22 - run modes: 00 stop, 01 free, 10 edge clear, 11 match clear.
// R23 - overflow flag sets on FFFFH to 0000H rollover.
// R24 - capture source select: 0 second input, 1 reverse first.
// R25 - both inputs synchronised and edge detected before use.
`include "tmc_regs.vh"
module tmc_timer #(
  parameter WIDTH = 16
) (
  input  wire        mclk,
  input  wire        srst,
  input  wire [4:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  input  wire [3:0]  avs_byteenable,
  output wire        avs_waitrequest,
  output wire [31:0] avs_readdata,
  input  wire        timer_input_first,
  input  wire        timer_input_second,
  output reg         match_irq_first,
  output reg         match_irq_second,
  output reg         timer_output_pin
);
  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  reg  [WIDTH-1:0] count;
  reg  [WIDTH-1:0] capture_compare_first;
  reg  [WIDTH-1:0] capture_compare_second;
  reg  [7:0]       timer_mode_control;
  reg  [7:0]       capcmp_control;
  reg  [7:0]       output_pin_control;
  reg  [7:0]       prescaler_edge_select;
  reg              prev_count_zero;
  reg  [31:0]      rd_word;
  wire [2:0]       reg_index;
  wire             wr_stb;
  wire             rd_stb;
  wire             in1_valid;
  wire             in1_reverse;
  wire             in2_valid;
  wire             in2_reverse;
  wire [1:0]       run_mode;
  wire             running;
  wire             ccf_capture;
  wire             ccs_capture;
  wire             cap_src;
  wire             oneshot_en;
  wire             soft_trig;
  wire             match_first;
  wire             match_second;
  wire             clear_evt;
  wire             wr_mode;
  wire             overflow;
  wire             cap_first_evt;
  // ---------------------------------------------------------------
  // bus and input stages
  // ---------------------------------------------------------------
  tmc_avalon_slave u_bus (
    .mclk            (mclk),
    .srst            (srst),
    .avs_address     (avs_address),
    .avs_read        (avs_read),
    .avs_write       (avs_write),
    .avs_writedata   (avs_writedata),
    .avs_byteenable  (avs_byteenable),
    .avs_waitrequest (avs_waitrequest),
    .avs_readdata    (avs_readdata),
    .rd_word         (rd_word),
    .reg_index       (reg_index),
    .wr_stb          (wr_stb),
    .rd_stb          ()
  );
  tmc_edge_detect u_in1 ( // R25
    .mclk         (mclk),
    .srst         (srst),
    .pin          (timer_input_first),
    .edge_sel     (prescaler_edge_select[`TMC_EDGE_IN1_LO+1:
                                         `TMC_EDGE_IN1_LO]),
    .valid_edge   (in1_valid),
    .reverse_edge (in1_reverse)
  );
  tmc_edge_detect u_in2 ( // R25
    .mclk         (mclk),
    .srst         (srst),
    .pin          (timer_input_second),
    .edge_sel     (prescaler_edge_select[`TMC_EDGE_IN2_LO+1:
                                         `TMC_EDGE_IN2_LO]),
    .valid_edge   (in2_valid),
    .reverse_edge (in2_reverse)
  );
  // ---------------------------------------------------------------
  // control decode
  // ---------------------------------------------------------------
  assign run_mode    = {timer_mode_control[`TMC_MODE_RUN_HI],
                        timer_mode_control[`TMC_MODE_RUN_LO]};
  assign running     = (run_mode != `TMC_RUN_STOP); // R22
  assign ccf_capture = capcmp_control[`TMC_CAP_CCF_BIT];
  assign ccs_capture = capcmp_control[`TMC_CAP_CCS_BIT];
  assign cap_src     = capcmp_control[`TMC_CAP_SRC_BIT];
  assign oneshot_en  = output_pin_control[`TMC_OUT_OSPE_BIT];
  assign wr_mode     = wr_stb & (reg_index == `TMC_IDX_MODE);
  assign soft_trig   = wr_stb & (reg_index == `TMC_IDX_OUTCTL) &
                       avs_writedata[`TMC_OUT_OSPT_BIT];
  assign overflow    = running & (count == {WIDTH{1'b1}});
  // zero compare only hits after the count leaves 0000H
  assign match_first  = running & ~ccf_capture &
                        (count == capture_compare_first) &
                        ((count != {WIDTH{1'b0}}) | prev_count_zero); // R19
  assign match_second = running & ~ccs_capture &
                        (count == capture_compare_second) &
                        ((count != {WIDTH{1'b0}}) | prev_count_zero); // R19
  assign clear_evt =
    ((run_mode == `TMC_RUN_CLR_EDGE) & in1_valid) |                 // R4
    ((run_mode == `TMC_RUN_CLR_MATCH) & match_first) |              // R5
    (running & oneshot_en & (soft_trig | in1_valid));               // R6
  assign cap_first_evt = running & ccf_capture &
                         (cap_src ? in1_reverse : in2_valid);       // R24
  // ---------------------------------------------------------------
  // counter
  // ---------------------------------------------------------------
  always @(posedge mclk) begin
    if (srst) begin
      count           <= `TMC_RST_COUNT; // R3
      prev_count_zero <= 1'b0;
    end else begin
      if (!running)
        count <= `TMC_RST_COUNT; // R3
      else if (clear_evt)
        count <= {WIDTH{1'b0}};
      else
        count <= count + {{(WIDTH-1){1'b0}}, 1'b1}; // R1
      // set when the count wraps or is cleared while running
      prev_count_zero <= running & (overflow | clear_evt); // R19
    end
  end
  // ---------------------------------------------------------------
  // registers and captures
  // ---------------------------------------------------------------
  always @(posedge mclk) begin
    if (srst) begin
      capture_compare_first  <= `TMC_RST_CC; // R7
      capture_compare_second <= `TMC_RST_CC; // R7
      timer_mode_control     <= `TMC_RST_CTL;
      capcmp_control         <= `TMC_RST_CTL;
      output_pin_control     <= `TMC_RST_CTL;
      prescaler_edge_select  <= `TMC_RST_CTL;
    end else begin
      // a capture in the same cycle as a stop write stores the running count
      if (cap_first_evt)
        capture_compare_first <= count; // R10 R13 R15
      else if (wr_stb & (reg_index == `TMC_IDX_CCF))
        capture_compare_first <= avs_writedata[WIDTH-1:0]; // R9
      if (running & ccs_capture & in1_valid)
        capture_compare_second <= count; // R12 R15 R21
      else if (wr_stb & (reg_index == `TMC_IDX_CCS))
        capture_compare_second <= avs_writedata[WIDTH-1:0]; // R7
      if (wr_mode) begin
        timer_mode_control <= {4'h0, avs_writedata[3:1],
                               avs_writedata[`TMC_MODE_OVF_BIT] |
                               overflow};
        if (avs_writedata[`TMC_MODE_RUN_HI:`TMC_MODE_RUN_LO] == 2'h0)
          timer_mode_control[`TMC_MODE_OVF_BIT] <= 1'b0;
      end else if (overflow)
        timer_mode_control[`TMC_MODE_OVF_BIT] <= 1'b1; // R23
      if (wr_stb & (reg_index == `TMC_IDX_CAPCTL))
        capcmp_control <= {5'h00, avs_writedata[2:0]};
      if (wr_stb & (reg_index == `TMC_IDX_OUTCTL))
        output_pin_control <= {2'h0, avs_writedata[5:0]};
      if (wr_stb & (reg_index == `TMC_IDX_EDGESEL))
        prescaler_edge_select <= {4'h0, avs_writedata[3:0]};
    end
  end
  // ---------------------------------------------------------------
  // interrupts and output pin
  // ---------------------------------------------------------------
  always @(posedge mclk) begin
    if (srst) begin
      match_irq_first  <= 1'b0;
      match_irq_second <= 1'b0;
      timer_output_pin <= 1'b0;
    end else begin
      // reverse-phase capture raises nothing; second input does only while cap_src selects reverse first
      match_irq_first  <= match_first |
                          (running & ccf_capture & cap_src &
                           in2_valid); // R9 R20
      match_irq_second <= match_second; // R11
      if (!running)
        timer_output_pin <= 1'b0;
      else if (match_first | match_second)
        timer_output_pin <= ~timer_output_pin;
    end
  end
  // ---------------------------------------------------------------
  // read mux
  // ---------------------------------------------------------------
  always @* begin
    rd_word = 32'h00000000;
    case (reg_index)
      `TMC_IDX_COUNT:   rd_word[WIDTH-1:0] = running ? count :
                                             {WIDTH{1'b0}}; // R2
      `TMC_IDX_CCF:     rd_word[WIDTH-1:0] = capture_compare_first;
      `TMC_IDX_CCS:     rd_word[WIDTH-1:0] = capture_compare_second;
      `TMC_IDX_MODE:    rd_word[7:0] = timer_mode_control;
      `TMC_IDX_CAPCTL:  rd_word[7:0] = capcmp_control;
      `TMC_IDX_OUTCTL:  rd_word[7:0] = output_pin_control;
      `TMC_IDX_EDGESEL: rd_word[7:0] = prescaler_edge_select;
      default:          rd_word = 32'h00000000;
    endcase
  end
endmodule

/* File: verif/tmc_timer_chk.sv */
// ------------
// port checker
// ------------
module tmc_timer_chk (
  input wire logic        mclk,
  input wire logic        srst,
  input wire logic [4:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic        avs_waitrequest,
  input wire logic [31:0] avs_readdata,
  input wire logic        match_irq_first,
  input wire logic        match_irq_second,
  input wire logic        timer_output_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  wait_first_a: assert property
    ($rose(avs_read) || $rose(avs_write) |-> avs_waitrequest)
    else $error("request answered without wait cycle");
  wait_once_a: assert property
    ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("more than one wait cycle");
  irq_first_a: assert property (match_irq_first |=> !match_irq_first)
    else $error("first match pulse too long");
  irq_second_a: assert property (match_irq_second |=> !match_irq_second)
    else $error("second match pulse too long");
  reset_quiet_a: assert property ($fell(srst) |->
    !match_irq_first && !match_irq_second && !timer_output_pin)
    else $error("outputs active after reset");
  read_upper_a: assert property (avs_read && !avs_waitrequest |->
    avs_readdata[31:16] == 16'h0000)
    else $error("upper read bits not zero");
  unmapped_read_a: assert property (avs_read && !avs_waitrequest &&
    avs_address[4:2] == 3'h7 |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  rdata_hold_a: assert property (!avs_read |=> $stable(avs_readdata))
    else $error("read data changed without read");
endmodule

bind tmc_timer tmc_timer_chk chk_u (
  .mclk, .srst, .avs_address, .avs_read, .avs_write, .avs_waitrequest,
  .avs_readdata, .match_irq_first, .match_irq_second, .timer_output_pin
);

/* File: verif/tmc_pin_drv.sv */
// ------------------
// timer input pins
// ------------------
module tmc_pin_drv (
  input  wire logic mclk,
  output logic      pin_first,
  output logic      pin_second
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    pin_first = 1'b0;
    pin_second = 1'b0;
  end
  // pulse then quiet time for sync and edge detect
  task automatic pulse(input bit sel, input int len);
    @(posedge mclk);
    if (sel) pin_second <= 1'b1;
    else pin_first <= 1'b1;
    repeat (len) @(posedge mclk);
    if (sel) pin_second <= 1'b0;
    else pin_first <= 1'b0;
    repeat (8) @(posedge mclk);
  endtask
endmodule

/* File: verif/tmc_timer_test.sv */
// -------------
// testbench top
// -------------
module tmc_timer_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic        mclk, srst, avs_read, avs_write, avs_waitrequest;
  logic        irq1, irq2, tout, in1, in2;
  logic [4:0]  avs_address;
  logic [3:0]  avs_byteenable, be;
  logic [31:0] avs_writedata, avs_readdata, rd, a, b, seed;
  int          error_cnt = 0, comparisons = 0, k;
  int          n1 = 0, n2 = 0, cyc = 0, last1 = 0, per1 = 0;
  int          hr = 0, hw = 0;
  int          mdl[8];

  tmc_timer dut_u (.mclk(mclk), .srst(srst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_waitrequest(avs_waitrequest), .avs_readdata(avs_readdata),
    .timer_input_first(in1), .timer_input_second(in2),
    .match_irq_first(irq1), .match_irq_second(irq2),
    .timer_output_pin(tout));
  tmc_pin_drv pins_u (.mclk(mclk), .pin_first(in1), .pin_second(in2));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (irq1 === 1'b1) begin
      n1 <= n1 + 1;
      per1 <= cyc - last1;
      last1 <= cyc;
    end
    if (irq2 === 1'b1) n2 <= n2 + 1;
    if (tout === 1'b1) hr <= hr + 1;
    else if (hr != 0) begin
      hw <= hr;
      hr <= 0;
    end
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic test_done();
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic bus(input bit w, input logic [4:0] adr,
                     input logic [31:0] d);
    int n;
    n = 0;
    avs_address <= adr;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_write <= w;
    avs_read <= !w;
    do begin
      @(posedge mclk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (w && be == 4'hf && adr[4:2] inside {3'h1, 3'h2})
      mdl[adr[4:2]] = d & 32'hffff;
    @(posedge mclk);
    if (n >= 20) begin
      error_cnt++;
      test_done();
    end
  endtask

  task automatic wr(input logic [4:0] adr, input logic [31:0] d);
    bus(1'b1, adr, d);
  endtask

  task automatic rg(input logic [4:0] adr);
    bus(1'b0, adr, 32'h0);
  endtask

  initial begin
    seed = 32'he8d9;
    be = 4'hf;
    srst = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 5'h00;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hf;
    repeat (6) @(posedge mclk);
    srst <= 1'b0;
    @(posedge mclk);
    for (int i = 0; i < 8; i++) begin
      rg(5'(i * 4));
      cmp(rd, 32'h0);
    end
    wr(5'h0c, 32'h4);
    repeat (30) @(posedge mclk);
    cmp(n1 + n2, 0);
    rg(5'h00);
    a = rd;
    rg(5'h00);
    cmp(rd - a, 3);
    repeat (65536) @(posedge mclk);
    rg(5'h0c);
    cmp(rd & 32'h1, 1);
    cmp(n1 * 2 + n2, 3);
    wr(5'h0c, 32'h0);
    rg(5'h00);
    cmp(rd, 0);
    wr(5'h04, rnd() & 32'hffff);
    wr(5'h08, rnd() & 32'hffff);
    be = 4'h1;
    wr(5'h04, ~rd);
    be = 4'hf;
    wr(5'h00, 32'h1234);
    rg(5'h04);
    cmp(rd, mdl[1]);
    rg(5'h08);
    cmp(rd, mdl[2]);
    rg(5'h00);
    cmp(rd, 0);
    a = 3 + rnd() % 8;
    wr(5'h04, a);
    wr(5'h08, a - 2);
    wr(5'h0c, 32'hc);
    repeat (60) @(posedge mclk);
    cmp(per1, a + 1);
    cmp(hw, 2);
    wr(5'h0c, 32'h0);
    wr(5'h10, 32'h5);
    wr(5'h18, 32'h5);
    wr(5'h0c, 32'h4);
    repeat (40) @(posedge mclk);
    pins_u.pulse(1, 3 + rnd() % 4);
    rg(5'h04);
    a = rd;
    cmp(a > 40, 1);
    rg(5'h08);
    cmp(rd, mdl[2]);
    pins_u.pulse(0, 3 + rnd() % 4);
    rg(5'h08);
    cmp(rd > a, 1);
    wr(5'h0c, 32'h0);
    rg(5'h04);
    cmp(rd, a);
    wr(5'h10, 32'h7);
    wr(5'h0c, 32'h4);
    repeat (40) @(posedge mclk);
    k = n1;
    pins_u.pulse(1, 4);
    cmp(n1 - k, 1);
    rg(5'h04);
    cmp(rd, a);
    pins_u.pulse(0, 4);
    cmp(n1 - k, 1);
    rg(5'h08);
    b = rd;
    rg(5'h04);
    cmp(rd > b, 1);
    wr(5'h0c, 32'h0);
    wr(5'h10, 32'h0);
    wr(5'h04, 32'h50);
    wr(5'h0c, 32'h8);
    repeat (100) @(posedge mclk);
    pins_u.pulse(0, 3);
    rg(5'h00);
    cmp(rd < 30, 1);
    wr(5'h0c, 32'h0);
    wr(5'h08, 32'h10);
    wr(5'h14, 32'h20);
    wr(5'h0c, 32'h4);
    repeat (100) @(posedge mclk);
    wr(5'h14, 32'h60);
    rg(5'h00);
    cmp(rd < 10, 1);
    test_done();
  end
endmodule
